// [hw/sram_scrub_host.sv]
// host controller for an edac sram with an internal scrub engine
// assumes one sram on the pins and one ahb-lite master; hreadyout is always high
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module sram_scrub_host #(
    parameter int DEPTH = sram_scrub_host_pkg::DEPTH_WORDS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [sram_scrub_host_pkg::ADDR_W-1:0] sram_addr,
    input wire logic [31:0] dq_i,
    output logic [31:0] dq_o,
    output logic dq_oe,
    output logic sram_ce_n,
    output logic sram_oe_n,
    output logic sram_we_n,
    output logic scrub_role_select,
    input wire logic scrub_strobe_n_i,
    output logic scrub_strobe_n_o,
    output logic scrub_strobe_n_oe,
    input wire logic scrub_busy_n,
    input wire logic ecc_error_flag
);
    import sram_scrub_host_pkg::*;

    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);

    ctl_state_t state_reg, state_next;
    sweep_t sweep_reg;
    logic [1:0] ctrl_reg;
    logic [ADDR_W-1:0] addr_reg, sweep_addr_reg, sram_addr_reg;
    logic [31:0] wdata_reg, rdata_reg, period_reg, hybrid_reg, hrdata_reg, dq_o_reg;
    logic [15:0] errcnt_reg;
    logic [1:0] cmd_pend_reg;
    logic err_reg, src_sweep_reg, role_reg;
    logic ce_n_reg, oe_n_reg, we_n_reg, dq_oe_reg, strobe_o_reg, strobe_oe_reg;
    logic wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    logic [1:0] busy_ff, flag_ff, strobe_ff;
    logic [31:0] dq_ff1, dq_ff2;
    logic phase_exp, period_exp, phase_load, capture, flag_hit, sweep_step;
    logic [31:0] phase_val, status_w, rd_mux;
    logic ap_valid, wr_ctrl, wr_cmd, wr_status, wr_hybrid, wr_errcnt, dev_busy, slave_due;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stages feed nothing but the second
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 2'h3;
            flag_ff <= 2'h0;
            strobe_ff <= 2'h3;
            dq_ff1 <= 32'h0000_0000;
            dq_ff2 <= 32'h0000_0000;
        end else begin
            busy_ff <= {busy_ff[0], scrub_busy_n};
            flag_ff <= {flag_ff[0], ecc_error_flag};
            strobe_ff <= {strobe_ff[0], scrub_strobe_n_i};
            dq_ff1 <= dq_i;
            dq_ff2 <= dq_ff1;
        end
    end
    assign dev_busy = !busy_ff[1];

    ////////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states, registered read data
    assign ap_valid = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    assign status_w = {25'h0, strobe_ff[1], role_reg, dev_busy, err_reg,
                       sweep_reg != SW_NONE, cmd_pend_reg != 2'h0, state_reg != S_IDLE};

    always_comb begin
        case (haddr[7:0])
            OFS_CTRL: rd_mux = {30'h0, ctrl_reg};
            OFS_ADDR: rd_mux = {13'h0, addr_reg};
            OFS_WDATA: rd_mux = wdata_reg;
            OFS_RDATA: rd_mux = rdata_reg;
            OFS_STATUS: rd_mux = status_w;
            OFS_PERIOD: rd_mux = period_reg;
            OFS_HYBRID: rd_mux = hybrid_reg;
            OFS_ERRCNT: rd_mux = {16'h0, errcnt_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= ap_valid && hwrite;
            if (ap_valid) begin
                wr_ofs_reg <= haddr[7:0];
            end
            if (ap_valid && !hwrite) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    assign wr_ctrl = wr_pend_reg && (wr_ofs_reg == OFS_CTRL);
    assign wr_cmd = wr_pend_reg && (wr_ofs_reg == OFS_CMD);
    assign wr_status = wr_pend_reg && (wr_ofs_reg == OFS_STATUS);
    assign wr_hybrid = wr_pend_reg && (wr_ofs_reg == OFS_HYBRID);
    assign wr_errcnt = wr_pend_reg && (wr_ofs_reg == OFS_ERRCNT);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            addr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            period_reg <= PERIOD_RST;
        end else if (wr_pend_reg) begin
            if (wr_ofs_reg == OFS_CTRL) ctrl_reg <= hwdata[1:0];
            if (wr_ofs_reg == OFS_ADDR) addr_reg <= hwdata[ADDR_W-1:0];
            if (wr_ofs_reg == OFS_WDATA) wdata_reg <= hwdata;
            if (wr_ofs_reg == OFS_PERIOD) period_reg <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // role select: fixed master bit or a timed hybrid window
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hybrid_reg <= 32'h0000_0000;
            role_reg <= 1'b0;
        end else begin
            if (wr_hybrid) begin
                hybrid_reg <= hwdata;
            end else if (hybrid_reg != 32'h0000_0000) begin
                hybrid_reg <= hybrid_reg - 32'h0000_0001;
            end
            role_reg <= ctrl_reg[CTRL_MASTER] || (hybrid_reg != 32'h0000_0000);
        end
    end
    assign scrub_role_select = role_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // command, sweep and error bookkeeping
    assign capture = (state_reg == S_RD) && phase_exp;
    assign flag_hit = capture && flag_ff[1];
    assign sweep_step = (state_reg == S_REC) && phase_exp && src_sweep_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_pend_reg <= 2'h0;
        end else if (wr_cmd && cmd_pend_reg == 2'h0) begin
            cmd_pend_reg <= {hwdata[CMD_WRITE], hwdata[CMD_READ] && !hwdata[CMD_WRITE]};
        end else if (state_reg == S_IDLE && state_next != S_IDLE && !src_sweep_next()) begin
            cmd_pend_reg <= 2'h0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sweep_reg <= SW_NONE;
            sweep_addr_reg <= '0;
        end else if (sweep_reg == SW_NONE) begin
            sweep_addr_reg <= '0;
            if (wr_ctrl && hwdata[CTRL_FILL_GO]) sweep_reg <= SW_FILL;
            else if (wr_ctrl && hwdata[CTRL_COPY_GO]) sweep_reg <= SW_COPY;
        end else if (sweep_step) begin
            if (sweep_addr_reg == LAST_ADDR) begin
                sweep_reg <= SW_NONE;
            end else begin
                sweep_addr_reg <= sweep_addr_reg + 1'b1;
            end
        end
    end

    // a flag arriving with the clear write still sets the bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            err_reg <= 1'b0;
            errcnt_reg <= 16'h0000;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (flag_hit) err_reg <= 1'b1;
            else if (wr_status && hwdata[ST_ERR]) err_reg <= 1'b0;
            if (flag_hit && errcnt_reg != 16'hFFFF) errcnt_reg <= errcnt_reg + 16'h0001;
            else if (wr_errcnt && !flag_hit) errcnt_reg <= 16'h0000;
            if (capture && !src_sweep_reg) rdata_reg <= dq_ff2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin sequencer
    function automatic logic src_sweep_next();
        return (cmd_pend_reg == 2'h0);
    endfunction

    assign slave_due = !role_reg && ctrl_reg[CTRL_SLAVE_AUTO] && period_exp;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (role_reg && dev_busy) begin
                    state_next = S_IDLE;
                end else if (cmd_pend_reg[CMD_WRITE]) begin
                    state_next = S_WR;
                end else if (cmd_pend_reg[CMD_READ]) begin
                    state_next = S_RD;
                end else if (sweep_reg == SW_FILL) begin
                    state_next = S_WR;
                end else if (sweep_reg == SW_COPY) begin
                    state_next = S_RD;
                end else if (slave_due) begin
                    state_next = S_STROBE;
                end
            end
            S_RD: if (phase_exp) state_next = (src_sweep_reg) ? S_WR : S_IDLE;
            S_WR: if (phase_exp) state_next = S_REC;
            S_REC: if (phase_exp) state_next = S_IDLE;
            S_STROBE: if (phase_exp) state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    assign phase_load = (state_next != state_reg);
    always_comb begin
        case (state_next)
            S_RD: phase_val = 32'(ACCESS_CYC + SYNC_CYC - 1);
            S_WR: phase_val = 32'(WE_CYC - 1);
            S_REC: phase_val = 32'(REC_CYC - 1);
            S_STROBE: phase_val = 32'(STROBE_CYC - 1);
            default: phase_val = 32'h0000_0000;
        endcase
    end

    cycle_timer #(.W(32)) phase_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(phase_load),
        .load_val(phase_val),
        .expired(phase_exp)
    );

    // period restarts when the strobe begins, so spacing is start to start
    cycle_timer #(.W(32)) period_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(state_reg == S_IDLE && state_next == S_STROBE),
        .load_val(period_reg),
        .expired(period_exp)
    );

    // pins are registered, all but strobe_oe_reg from the next state, so they change cleanly on edges
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
            src_sweep_reg <= 1'b0;
            sram_addr_reg <= '0;
            dq_o_reg <= 32'h0000_0000;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
            strobe_o_reg <= 1'b1;
            strobe_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == S_IDLE && state_next != S_IDLE && state_next != S_STROBE) begin
                src_sweep_reg <= src_sweep_next();
                sram_addr_reg <= src_sweep_next() ? sweep_addr_reg : addr_reg;
                dq_o_reg <= wdata_reg;
            end else if (capture && src_sweep_reg) begin
                dq_o_reg <= dq_ff2;
            end
            ce_n_reg <= !(state_next == S_RD || state_next == S_WR || state_next == S_REC);
            oe_n_reg <= (state_next != S_RD);
            we_n_reg <= (state_next != S_WR);
            dq_oe_reg <= (state_next == S_WR || state_next == S_REC);
            strobe_o_reg <= (state_next != S_STROBE);
            strobe_oe_reg <= !(ctrl_reg[CTRL_MASTER] || (hybrid_reg != 32'h0000_0000));
        end
    end

    assign sram_addr = sram_addr_reg;
    assign dq_o = dq_o_reg;
    assign dq_oe = dq_oe_reg;
    assign sram_ce_n = ce_n_reg;
    assign sram_oe_n = oe_n_reg;
    assign sram_we_n = we_n_reg;
    assign scrub_strobe_n_o = strobe_o_reg;
    assign scrub_strobe_n_oe = strobe_oe_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_no_access_busy;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == S_IDLE && role_reg && dev_busy) |=> ce_n_reg;
    endproperty
    a_no_access_busy: assert property (p_no_access_busy)
        else $error("memory access started during master scrub");

    property p_strobe_slave_only;
        @(posedge ref_clk) disable iff (rst)
        !scrub_strobe_n_o |-> scrub_strobe_n_oe && !role_reg;
    endproperty
    a_strobe_slave_only: assert property (p_strobe_slave_only)
        else $error("scrub strobe driven low outside slave mode");

    property p_strobe_width;
        @(posedge ref_clk) disable iff (rst)
        $fell(scrub_strobe_n_o) |-> !scrub_strobe_n_o [*6] ##1 scrub_strobe_n_o;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("scrub strobe low time wrong");

    property p_hybrid_role;
        @(posedge ref_clk) disable iff (rst)
        (hybrid_reg != 32'h0000_0000) |=> role_reg;
    endproperty
    a_hybrid_role: assert property (p_hybrid_role)
        else $error("role select low inside hybrid window");

    property p_fill_data;
        @(posedge ref_clk) disable iff (rst)
        (!we_n_reg && src_sweep_reg && sweep_reg == SW_FILL) |-> dq_oe_reg && dq_o_reg == wdata_reg;
    endproperty
    a_fill_data: assert property (p_fill_data)
        else $error("fill writes wrong data");

    property p_copy_back;
        @(posedge ref_clk) disable iff (rst)
        (capture && src_sweep_reg && sweep_reg == SW_COPY) |=> ##1 !we_n_reg && dq_o_reg == $past(dq_ff2, 2);
    endproperty
    a_copy_back: assert property (p_copy_back)
        else $error("sweep did not write back the read value");

    property p_sweep_step;
        @(posedge ref_clk) disable iff (rst)
        (sweep_step && sweep_addr_reg != LAST_ADDR) |=> sweep_addr_reg == $past(sweep_addr_reg) + 1'b1;
    endproperty
    a_sweep_step: assert property (p_sweep_step)
        else $error("sweep address did not step by one");

    property p_we_width;
        @(posedge ref_clk) disable iff (rst)
        $fell(we_n_reg) |-> !we_n_reg [*4] ##1 we_n_reg && !ce_n_reg && dq_oe_reg;
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write strobe width or hold wrong");

    property p_read_pins;
        @(posedge ref_clk) disable iff (rst)
        !oe_n_reg |-> !ce_n_reg && we_n_reg && !dq_oe_reg;
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("read phase pins inconsistent");

    property p_err_sticky;
        @(posedge ref_clk) disable iff (rst)
        flag_hit |=> err_reg;
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("error flag not recorded");

    c_strobe: cover property (@(posedge ref_clk) disable iff (rst) $fell(scrub_strobe_n_o));
    c_busy_wait: cover property (@(posedge ref_clk) disable iff (rst)
        state_reg == S_IDLE && role_reg && dev_busy && cmd_pend_reg != 2'h0);
    c_copy: cover property (@(posedge ref_clk) disable iff (rst) sweep_step && sweep_reg == SW_COPY);
    c_err: cover property (@(posedge ref_clk) disable iff (rst) flag_hit);
endmodule // sram_scrub_host

// [hw/sram_scrub_host_pkg.sv]
// constants, register map and state types of the edac sram host controller
// assumes a 250 MHz ref_clk and a 32-bit ahb-lite software port
package sram_scrub_host_pkg;

    // clock
    localparam int CLK_PERIOD_PS = 4000;

    // pin timing of the asynchronous sram, in ns as specified
    localparam int T_ACCESS_NS = 20;
    localparam int T_WE_NS = 15;
    localparam int T_REC_NS = 8;
    localparam int T_STROBE_NS = 24;
    // least times round up to whole cycles
    localparam int ACCESS_CYC = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WE_CYC = (T_WE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REC_CYC = (T_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_CYC = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // two flops of pin synchronisation lie between the pins and the capture
    localparam int SYNC_CYC = 2;

    // array geometry
    localparam int ADDR_W = 19;
    localparam int DEPTH_WORDS = 524288;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_PERIOD = 8'h18;
    localparam logic [7:0] OFS_HYBRID = 8'h1C;
    localparam logic [7:0] OFS_ERRCNT = 8'h20;

    // field positions
    localparam int CTRL_MASTER = 0;
    localparam int CTRL_SLAVE_AUTO = 1;
    localparam int CTRL_COPY_GO = 2;
    localparam int CTRL_FILL_GO = 3;
    localparam int CMD_READ = 0;
    localparam int CMD_WRITE = 1;
    localparam int ST_ENGINE_BUSY = 0;
    localparam int ST_CMD_PEND = 1;
    localparam int ST_SWEEP = 2;
    localparam int ST_ERR = 3;
    localparam int ST_DEV_BUSY = 4;
    localparam int ST_ROLE = 5;
    localparam int ST_DEV_STROBE = 6;

    // values after reset
    localparam logic [31:0] PERIOD_RST = 32'h0000_1000;
    localparam logic [1:0] CTRL_RST = 2'h0;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RD,
        S_WR,
        S_REC,
        S_STROBE
    } ctl_state_t;

    typedef enum logic [1:0] {
        SW_NONE,
        SW_COPY,
        SW_FILL
    } sweep_t;

endpackage

// [hw/cycle_timer.sv]
// loadable down counter; expired is high while the count stands at zero
// assumes load and load_val come from logic on ref_clk
`timescale 1ns/1ps
module cycle_timer #(
    parameter int W = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic expired
);
    logic [W-1:0] count_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_val;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign expired = (count_reg == '0);
endmodule // cycle_timer

// [testbench/sram_dev_model.sv]
// behavioural edac sram: data array, injected bit flips, scrub engine
// assumes one host on the pins; the flag reports both error kinds
`timescale 1ns/1ps
module sram_dev_model #(
    parameter int DEPTH = 8,
    parameter int MASTER_GAP_NS = 3000,
    // device control bits as software would program them: scrub allowed, correction on
    parameter bit SCRUB_OFF = 1'b0,
    parameter bit CORR_BYPASS = 1'b0
) (
    input wire logic [18:0] addr,
    input wire logic [31:0] dq_in,
    output logic [31:0] dq_out,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic role,
    input wire logic strobe_n,
    output logic drive_strobe_n,
    output logic busy_n,
    output logic flag
);
    logic [31:0] mem [DEPTH];
    logic [31:0] flip [DEPTH];
    logic [31:0] last;
    logic [18:0] ptr;
    wire rd = !ce_n && !oe_n;
    wire multi = $countones(flip[addr]) > 1;
    // stored word as it would leave the array, check bits never shown
    wire [31:0] val = (multi || CORR_BYPASS) ?
        mem[addr] ^ flip[addr] : mem[addr];
    // a read that collides with a scrub gets garbage; released bus shows the inverse
    assign #5 dq_out = rd ? (busy_n ? val : ~val) : ~last;
    assign flag = rd && flip[addr] != 32'h0000_0000;
    initial begin
        busy_n = 1'b1;
        drive_strobe_n = 1'b1;
        ptr = '0;
        last = '0;
        foreach (flip[i]) flip[i] = '0;
    end
    always @(rd or val) begin
        if (rd) last = val;
    end
    always @(posedge we_n) begin
        if (!ce_n) begin
            mem[addr] = dq_in;
            flip[addr] = '0;
        end
    end
    task automatic scrub();
        if (!SCRUB_OFF && !CORR_BYPASS) begin
            if ($countones(flip[ptr]) == 1) flip[ptr] = '0;
            ptr = 19'((ptr + 1) % DEPTH);
        end
    endtask
    always @(negedge strobe_n) begin
        if (!role) scrub();
    end
    always begin
        #MASTER_GAP_NS;
        if (role) begin
            busy_n = 1'b0;
            drive_strobe_n = 1'b0;
            #40 scrub();
            busy_n = 1'b1;
            drive_strobe_n = 1'b1;
        end
    end
endmodule // sram_dev_model

// [testbench/tb_top.sv]
// self-checking bench for the edac sram host controller
// assumes the behavioural sram model and an 8-word array
`timescale 1ns/1ps
module tb_top;
    import sram_scrub_host_pkg::*;
    typedef struct {logic [18:0] a; logic [31:0] d, f, q; logic e;} row_t;
    logic ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp, dq_oe, ce_n, oe_n, we_n;
    logic role, st_o, st_oe, busy_n, flag, dev_st_n, st_w;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, dq_o, dq_i, dq_dev, rv;
    logic [18:0] sram_addr;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    row_t rows [3] = '{'{19'h1, 32'hA5A5_0001, 32'h0000_0000, 32'hA5A5_0001, 1'b0},
        '{19'h2, 32'h1234_5678, 32'h0000_0010, 32'h1234_5678, 1'b1},
        '{19'h3, 32'h0F0F_F0F0, 32'h0000_0003, 32'h0F0F_F0F3, 1'b1}};
    assign hready = hreadyout;
    assign dq_i = dq_oe ? dq_o : dq_dev;
    // strobe line has a pull-up; either side may pull it low
    assign st_w = !((st_oe && !st_o) || !dev_st_n);
    sram_scrub_host #(.DEPTH(8)) sram_scrub_host_inst (.ref_clk(ref_clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sram_addr(sram_addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .sram_ce_n(ce_n), .sram_oe_n(oe_n), .sram_we_n(we_n), .scrub_role_select(role),
        .scrub_strobe_n_i(st_w), .scrub_strobe_n_o(st_o), .scrub_strobe_n_oe(st_oe),
        .scrub_busy_n(busy_n), .ecc_error_flag(flag));
    sram_dev_model #(.DEPTH(8)) sram_dev_model_inst (.addr(sram_addr), .dq_in(dq_i),
        .dq_out(dq_dev), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .role(role),
        .strobe_n(st_w), .drive_strobe_n(dev_st_n), .busy_n(busy_n), .flag(flag));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one single transfer; caller stands just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            rd(OFS_STATUS);
            n++;
        end while (rv[2:0] !== 3'h0 && n < 500);
        check("idle", {29'h0, rv[2:0]}, 32'h0000_0000);
    endtask
    task automatic mem_op(input logic [18:0] a, input logic w, input logic [31:0] d);
        wr(OFS_ADDR, {13'h0, a});
        wr(OFS_WDATA, d);
        wr(OFS_CMD, w ? 32'h0000_0002 : 32'h0000_0001);
        wait_idle();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ceiling well above the thousand or so cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = '0;
        hwdata = '0;
        hsize = 3'b010;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            mem_op(rows[i].a, 1'b1, rows[i].d);
            check("stored", sram_dev_model_inst.mem[rows[i].a], rows[i].d);
            sram_dev_model_inst.flip[rows[i].a] = rows[i].f;
            wr(OFS_ERRCNT, 32'h0000_0000);
            wr(OFS_STATUS, 32'h0000_0008);
            mem_op(rows[i].a, 1'b0, 32'h0000_0000);
            rd(OFS_RDATA);
            check("rdata", rv, rows[i].q);
            rd(OFS_ERRCNT);
            check("errcnt", rv, {31'h0, rows[i].e});
        end
        check("array kept", sram_dev_model_inst.flip[2], 32'h0000_0010);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("reset pins", {23'h0, hreadyout, st_o, st_oe, ce_n, oe_n, we_n, dq_oe, role, hresp},
            32'h0000_01B8);
        check("reset addr", {13'h0, sram_addr}, 32'h0000_0000);
        check("reset hrdata", hrdata, 32'h0000_0000);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_PERIOD);
        check("period", rv, PERIOD_RST);
        rd(8'h40);
        check("unmapped", rv, 32'h0000_0000);
        // slave scrub: repeated strobes sweep all eight words
        wr(OFS_PERIOD, 32'h0000_0014);
        wr(OFS_CTRL, 32'h0000_0002);
        repeat (240) @(posedge ref_clk);
        wr(OFS_CTRL, 32'h0000_0000);
        check("repaired", sram_dev_model_inst.flip[2], 32'h0000_0000);
        check("multi kept", sram_dev_model_inst.flip[3], 32'h0000_0003);
        // let a strobe already under way finish before the role changes
        repeat (8) @(posedge ref_clk);
        // hybrid window: role select high for the programmed cycles only
        wr(OFS_HYBRID, 32'h0000_0020);
        @(posedge ref_clk);
        rd(OFS_STATUS);
        check("hybrid on", {30'h0, role, rv[ST_ROLE]}, 32'h0000_0003);
        repeat (40) @(posedge ref_clk);
        check("hybrid off", {31'h0, role}, 32'h0000_0000);
        // master mode: a read issued during a device scrub must wait it out
        wr(OFS_ADDR, 32'h0000_0001);
        wr(OFS_CTRL, 32'h0000_0001);
        wait (busy_n === 1'b0);
        @(posedge ref_clk);
        check("role", {31'h0, role}, 32'h0000_0001);
        // command lands while the device still reports busy
        wr(OFS_CMD, 32'h0000_0001);
        wait_idle();
        rd(OFS_RDATA);
        check("busy read", rv, 32'hA5A5_0001);
        wr(OFS_WDATA, 32'h5A5A_C3C3);
        wr(OFS_CTRL, 32'h0000_0008);
        wait_idle();
        check("fill lo", sram_dev_model_inst.mem[0], 32'h5A5A_C3C3);
        check("fill hi", sram_dev_model_inst.mem[7], 32'h5A5A_C3C3);
        // copy sweep reads each word and writes the corrected value back
        sram_dev_model_inst.flip[4] = 32'h0000_0100;
        wr(OFS_ERRCNT, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0004);
        wait_idle();
        check("copy data", sram_dev_model_inst.mem[4], 32'h5A5A_C3C3);
        check("copy fixed", sram_dev_model_inst.flip[4], 32'h0000_0000);
        rd(OFS_ERRCNT);
        check("copy errcnt", rv, 32'h0000_0001);
        tally_and_finish();
    end
endmodule // tb_top
